//--- rtl/async_serial_uart.sv
// Asynchronous serial transmitter/receiver with optional FIFOs and interrupts
`timescale 1ns/10ps
module async_serial_uart
    import uart_pkg::*;
#(
    parameter int unsigned FIFO_DEPTH = FIFO_DEPTH_DEF
)(
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire uart_pkg::lineCfg_type    lineCfg,
    input  wire logic [15:0]              divisor,
    input  wire logic                     srcSel,
    input  wire logic                     fifoEn,
    input  wire logic                     rxFifoClear,
    input  wire logic                     txFifoClear,
    input  wire logic [1:0]               rxTrigSel,
    input  wire uart_pkg::intEnable_type  intEnable,
    input  wire logic                     txWrite,
    input  wire logic [7:0]               txData,
    input  wire logic                     rxRead,
    input  wire logic                     intIdRead,
    input  wire logic                     lineStatusRead,
    input  wire logic                     rxPin,
    output logic [7:0]                    rxDataOut,
    output uart_pkg::lineStatus_type      lineStatus,
    output uart_pkg::intId_type           intId,
    output logic                          irq,
    output logic                          txPin
);
    import uart_pkg::*;

    localparam int unsigned PW = $clog2(FIFO_DEPTH);

    // Elaboration check on FIFO shape
    if (FIFO_DEPTH < 2 || FIFO_DEPTH != (1 << PW) || FIFO_DEPTH < 16)
        $error("FIFO_DEPTH must be a power of two, at least 16 entries");

    logic [5:0]     srcAcc_reg;
    logic [6:0]     srcSum;
    logic           srcTick;
    logic [15:0]    divCnt_reg;
    logic           baudTick_reg;
    logic           fifoEnPrev_reg;
    logic           fifoFlush;
    logic [PW:0]    cap;

    // Fractional divider from the reference clock gives the source rate
    assign srcSum  = {1'b0, srcAcc_reg} + {1'b0, (srcSel ? STEP_LO : STEP_HI)};
    assign srcTick = srcSum >= {1'b0, ACC_MOD};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            srcAcc_reg <= 6'h00;
        else
            srcAcc_reg <= srcTick ? 6'(srcSum - {1'b0, ACC_MOD}) : srcSum[5:0];
    end

    // Divisor counter; 0 halts the generator, 32 at 16 MHz gives MIDI
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            divCnt_reg   <= 16'h0000;
            baudTick_reg <= 1'b0;
        end
        else
        begin
            baudTick_reg <= 1'b0;
            if (srcTick && divisor != 16'h0000)
            begin
                if (divCnt_reg >= divisor - 16'h0001)
                begin
                    divCnt_reg   <= 16'h0000;
                    baudTick_reg <= 1'b1;
                end
                else
                    divCnt_reg <= divCnt_reg + 16'h0001;
            end
        end
    end

    // FIFO mode changes flush both queues
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            fifoEnPrev_reg <= 1'b0;
        else
            fifoEnPrev_reg <= fifoEn;
    end
    assign fifoFlush = fifoEn != fifoEnPrev_reg;
    assign cap       = fifoEn ? (PW+1)'(FIFO_DEPTH) : (PW+1)'(1);

    // Transmit queue
    logic [7:0]     txMem [FIFO_DEPTH];
    logic [PW-1:0]  txWr_reg;
    logic [PW-1:0]  txRd_reg;
    logic [PW:0]    txCount_reg;
    logic           txPush;
    logic           txPop;

    assign txPush = txWrite && (txCount_reg < cap);

    always_ff @(posedge ref_clk)
    begin
        if (txPush)
            txMem[txWr_reg] <= txData;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || txFifoClear || fifoFlush)
        begin
            txWr_reg    <= '0;
            txRd_reg    <= '0;
            txCount_reg <= '0;
        end
        else
        begin
            if (txPush)
                txWr_reg <= txWr_reg + 1'b1;
            if (txPop)
                txRd_reg <= txRd_reg + 1'b1;
            txCount_reg <= txCount_reg + (PW+1)'(txPush) - (PW+1)'(txPop);
        end
    end

    // Transmit shifter
    txState_type    txState_reg;
    logic [7:0]     txShift_reg;
    logic [2:0]     txBit_reg;
    logic [5:0]     txTick_reg;
    logic           txParity_reg;
    logic [7:0]     txHead;
    logic [2:0]     lastBit;
    logic [5:0]     stopTicks;
    logic           txBitEnd;

    assign txHead    = txMem[txRd_reg] & (8'hFF >> (2'h3 - lineCfg.wordLen));
    assign lastBit   = {1'b1, lineCfg.wordLen};
    assign stopTicks = !lineCfg.twoStop ? TICKS_BIT :
                       (lineCfg.wordLen == LEN5 ? TICKS_STOP_1P5 : TICKS_STOP_2);
    assign txBitEnd  = baudTick_reg &&
                       txTick_reg == (txState_reg == TX_STOP ? stopTicks : TICKS_BIT) - 6'h01;
    assign txPop     = txState_reg == TX_IDLE && txCount_reg != '0;

    // Serialiser: start, data LSB first, parity, stop
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            txState_reg  <= TX_IDLE;
            txShift_reg  <= 8'h00;
            txBit_reg    <= 3'h0;
            txTick_reg   <= 6'h00;
            txParity_reg <= 1'b0;
        end
        else
        begin
            if (baudTick_reg)
                txTick_reg <= txBitEnd ? 6'h00 : txTick_reg + 6'h01;
            unique case (txState_reg)
                TX_IDLE:
                begin
                    txTick_reg <= 6'h00;
                    if (txPop)
                    begin
                        txShift_reg  <= txHead;
                        txBit_reg    <= 3'h0;
                        txParity_reg <= lineCfg.stickParity ? !lineCfg.evenParity :
                                        (^txHead) ^ !lineCfg.evenParity;
                        txState_reg  <= TX_START;
                    end
                end
                TX_START:
                    if (txBitEnd)
                        txState_reg <= TX_DATA;
                TX_DATA:
                    if (txBitEnd)
                    begin
                        txShift_reg <= txShift_reg >> 1;
                        txBit_reg   <= txBit_reg + 3'h1;
                        if (txBit_reg == lastBit)
                            txState_reg <= lineCfg.parityEn ? TX_PARITY : TX_STOP;
                    end
                TX_PARITY:
                    if (txBitEnd)
                        txState_reg <= TX_STOP;
                TX_STOP:
                    if (txBitEnd)
                        txState_reg <= TX_IDLE;
            endcase
        end
    end

    // Line driver, break forces low
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            txPin <= 1'b1;
        else if (lineCfg.breakCtl)
            txPin <= 1'b0;
        else
            unique case (txState_reg)
                TX_IDLE:   txPin <= 1'b1;
                TX_START:  txPin <= 1'b0;
                TX_DATA:   txPin <= txShift_reg[0];
                TX_PARITY: txPin <= txParity_reg;
                TX_STOP:   txPin <= 1'b1;
            endcase
    end

    // Receive input synchroniser and glitch filter
    logic           rxSync1_reg;
    logic           rxSync2_reg;
    logic           rxLine_reg;
    logic [1:0]     filtCnt_reg;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rxSync1_reg <= 1'b1;
            rxSync2_reg <= 1'b1;
            rxLine_reg  <= 1'b1;
            filtCnt_reg <= 2'h0;
        end
        else
        begin
            rxSync1_reg <= rxPin;
            rxSync2_reg <= rxSync1_reg;
            if (rxSync2_reg == rxLine_reg)
                filtCnt_reg <= 2'h0;
            else if (baudTick_reg)
            begin
                if (filtCnt_reg == FILTER_TICKS - 2'h1)
                begin
                    rxLine_reg  <= rxSync2_reg;
                    filtCnt_reg <= 2'h0;
                end
                else
                    filtCnt_reg <= filtCnt_reg + 2'h1;
            end
        end
    end

    // Receive shifter
    rxState_type    rxState_reg;
    logic [7:0]     rxShift_reg;
    logic [2:0]     rxBit_reg;
    logic [5:0]     rxTick_reg;
    logic           rxParBit_reg;
    logic           rxPush;
    logic [7:0]     rxAligned;
    logic           rxParityBad;
    rxEntry_type    rxEntry;

    assign rxAligned   = rxShift_reg >> (2'h3 - lineCfg.wordLen);
    assign rxParityBad = lineCfg.parityEn && (rxParBit_reg != (lineCfg.stickParity ?
                         !lineCfg.evenParity : (^rxAligned) ^ !lineCfg.evenParity));
    assign rxPush      = rxState_reg == RX_STOP && baudTick_reg && rxTick_reg == TICKS_BIT - 6'h01;
    assign rxEntry     = '{breakInt:  !rxLine_reg && rxAligned == 8'h00 &&
                                      !(lineCfg.parityEn && rxParBit_reg),
                           frameErr:  !rxLine_reg,
                           parityErr: rxParityBad,
                           data:      rxAligned};

    // Sample at mid-bit, sixteen ticks apart
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rxState_reg  <= RX_IDLE;
            rxShift_reg  <= 8'h00;
            rxBit_reg    <= 3'h0;
            rxTick_reg   <= 6'h00;
            rxParBit_reg <= 1'b0;
        end
        else
        begin
            if (baudTick_reg)
                rxTick_reg <= rxTick_reg + 6'h01;
            unique case (rxState_reg)
                RX_IDLE:
                begin
                    rxTick_reg <= 6'h00;
                    if (!rxLine_reg)
                        rxState_reg <= RX_START;
                end
                RX_START:
                    if (baudTick_reg && rxTick_reg == TICKS_HALF - 6'h01)
                    begin
                        rxTick_reg  <= 6'h00;
                        rxBit_reg   <= 3'h0;
                        rxState_reg <= rxLine_reg ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (baudTick_reg && rxTick_reg == TICKS_BIT - 6'h01)
                    begin
                        rxTick_reg  <= 6'h00;
                        rxShift_reg <= {rxLine_reg, rxShift_reg[7:1]};
                        rxBit_reg   <= rxBit_reg + 3'h1;
                        if (rxBit_reg == lastBit)
                            rxState_reg <= lineCfg.parityEn ? RX_PARITY : RX_STOP;
                    end
                RX_PARITY:
                    if (baudTick_reg && rxTick_reg == TICKS_BIT - 6'h01)
                    begin
                        rxTick_reg   <= 6'h00;
                        rxParBit_reg <= rxLine_reg;
                        rxState_reg  <= RX_STOP;
                    end
                RX_STOP:
                    if (rxPush)
                        rxState_reg <= RX_IDLE;
            endcase
        end
    end

    // Receive queue
    rxEntry_type    rxMem [FIFO_DEPTH];
    logic [PW-1:0]  rxWr_reg;
    logic [PW-1:0]  rxRd_reg;
    logic [PW:0]    rxCount_reg;
    logic           rxStore;
    logic           rxPop;
    logic           rxOverrun;

    assign rxStore   = rxPush && (rxCount_reg < cap);
    assign rxOverrun = rxPush && !(rxCount_reg < cap);
    assign rxPop     = rxRead && rxCount_reg != '0;

    always_ff @(posedge ref_clk)
    begin
        if (rxStore)
            rxMem[rxWr_reg] <= rxEntry;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || rxFifoClear || fifoFlush)
        begin
            rxWr_reg    <= '0;
            rxRd_reg    <= '0;
            rxCount_reg <= '0;
        end
        else
        begin
            if (rxStore)
                rxWr_reg <= rxWr_reg + 1'b1;
            if (rxPop)
                rxRd_reg <= rxRd_reg + 1'b1;
            rxCount_reg <= rxCount_reg + (PW+1)'(rxStore) - (PW+1)'(rxPop);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            rxDataOut <= 8'h00;
        else
            rxDataOut <= (rxCount_reg != '0) ? rxMem[rxRd_reg].data : 8'h00; // No stale words
    end

    // Sticky line errors; a new error wins over the read that clears
    logic           overrun_reg;
    logic           parErr_reg;
    logic           frmErr_reg;
    logic           brk_reg;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            overrun_reg <= 1'b0;
            parErr_reg  <= 1'b0;
            frmErr_reg  <= 1'b0;
            brk_reg     <= 1'b0;
        end
        else
        begin
            overrun_reg <= rxOverrun || (overrun_reg && !lineStatusRead);
            parErr_reg  <= (rxStore && rxEntry.parityErr) || (parErr_reg && !lineStatusRead);
            frmErr_reg  <= (rxStore && rxEntry.frameErr) || (frmErr_reg && !lineStatusRead);
            brk_reg     <= (rxStore && rxEntry.breakInt) || (brk_reg && !lineStatusRead);
        end
    end

    // Character timeout while data waits in the receive FIFO
    logic [9:0]     idleCnt_reg;
    logic           timeout_reg;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b || !fifoEn || rxCount_reg == '0 || rxStore || rxPop)
        begin
            idleCnt_reg <= 10'h000;
            timeout_reg <= 1'b0;
        end
        else if (baudTick_reg && !timeout_reg)
        begin
            idleCnt_reg <= idleCnt_reg + 10'h001;
            if (idleCnt_reg == TIMEOUT_TICKS - 10'h001)
                timeout_reg <= 1'b1;
        end
    end

    // Transmit-empty event flag
    logic           thrFlag_reg;
    logic           thrEnPrev_reg;
    logic           txEmptyNow;
    logic           thrSet;

    assign txEmptyNow = txCount_reg == '0;
    assign thrSet     = (txPop && txCount_reg == (PW+1)'(1)) ||
                        (intEnable.thrEmpty && !thrEnPrev_reg && txEmptyNow);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            thrFlag_reg   <= 1'b0;
            thrEnPrev_reg <= 1'b0;
        end
        else
        begin
            thrEnPrev_reg <= intEnable.thrEmpty;
            thrFlag_reg   <= thrSet || (thrFlag_reg && !txPush &&
                             !(intIdRead && intId == INT_THR));
        end
    end

    // Prioritised interrupt cause
    logic           lineErr;
    logic           rxAvail;
    intId_type      intIdNext;

    assign lineErr = overrun_reg || parErr_reg || frmErr_reg || brk_reg;
    assign rxAvail = fifoEn ? rxCount_reg >= (PW+1)'(TRIG_LEVEL[rxTrigSel]) :
                     rxCount_reg != '0;

    always_comb
    begin
        if (intEnable.lineStat && lineErr)
            intIdNext = INT_LINE;
        else if (intEnable.rxData && rxAvail)
            intIdNext = INT_RXDATA;
        else if (intEnable.rxData && timeout_reg)
            intIdNext = INT_TIMEOUT;
        else if (intEnable.thrEmpty && thrFlag_reg)
            intIdNext = INT_THR;
        else
            intIdNext = INT_NONE;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            intId <= INT_NONE;
            irq   <= 1'b0;
        end
        else
        begin
            intId <= intIdNext;
            irq   <= intIdNext != INT_NONE;
        end
    end

    // Line status view
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
            lineStatus <= '{txEmpty: 1'b1, thrEmpty: 1'b1, default: 1'b0};
        else
            lineStatus <= '{rxFifoErr: fifoEn && lineErr,
                            txEmpty:   txEmptyNow && txState_reg == TX_IDLE,
                            thrEmpty:  txEmptyNow,
                            breakInt:  brk_reg,
                            frameErr:  frmErr_reg,
                            parityErr: parErr_reg,
                            overrun:   overrun_reg,
                            dataReady: rxCount_reg != '0};
    end

endmodule : async_serial_uart

//--- rtl/uart_pkg.sv
// Shared constants and types for the asynchronous serial port
package uart_pkg;

    // Reference and baud source rates, in MHz
    localparam int unsigned REF_CLK_MHZ = 25;
    localparam int unsigned SRC_HI_MHZ  = 24;
    localparam int unsigned SRC_LO_MHZ  = 16;
    localparam logic [5:0]  ACC_MOD     = 6'(REF_CLK_MHZ);
    localparam logic [5:0]  STEP_HI     = 6'(SRC_HI_MHZ);
    localparam logic [5:0]  STEP_LO     = 6'(SRC_LO_MHZ);

    // Bit timing in sixteenth-bit ticks
    localparam logic [5:0] TICKS_BIT      = 6'h10;
    localparam logic [5:0] TICKS_HALF     = 6'h08;
    localparam logic [5:0] TICKS_STOP_1P5 = 6'h18;
    localparam logic [5:0] TICKS_STOP_2   = 6'h20;
    localparam logic [1:0] FILTER_TICKS   = 2'h2;

    // Receive timeout: four character times of ten bits
    localparam int unsigned TIMEOUT_CHARS = 4;
    localparam int unsigned BITS_PER_CHAR = 10;
    localparam logic [9:0]  TIMEOUT_TICKS =
        10'(TIMEOUT_CHARS * BITS_PER_CHAR * 16);

    localparam int unsigned FIFO_DEPTH_DEF = 16;

    // Receive trigger levels selected by a 2-bit code
    localparam logic [4:0] TRIG_LEVEL [4] = '{5'h01, 5'h04, 5'h08, 5'h0E};

    typedef enum logic [1:0] {
        LEN5 = 2'b00,
        LEN6 = 2'b01,
        LEN7 = 2'b10,
        LEN8 = 2'b11
    } wordLen_type;

    typedef struct packed {
        logic        breakCtl;
        logic        stickParity;
        logic        evenParity;
        logic        parityEn;
        logic        twoStop;
        wordLen_type wordLen;
    } lineCfg_type;

    typedef struct packed {
        logic rxData;
        logic thrEmpty;
        logic lineStat;
    } intEnable_type;

    typedef struct packed {
        logic rxFifoErr;
        logic txEmpty;
        logic thrEmpty;
        logic breakInt;
        logic frameErr;
        logic parityErr;
        logic overrun;
        logic dataReady;
    } lineStatus_type;

    typedef struct packed {
        logic       breakInt;
        logic       frameErr;
        logic       parityErr;
        logic [7:0] data;
    } rxEntry_type;

    typedef enum logic [3:0] {
        INT_NONE    = 4'h1,
        INT_THR     = 4'h2,
        INT_RXDATA  = 4'h4,
        INT_LINE    = 4'h6,
        INT_TIMEOUT = 4'hC
    } intId_type;

    typedef enum logic [2:0] {
        TX_IDLE   = 3'b000,
        TX_START  = 3'b001,
        TX_DATA   = 3'b010,
        TX_PARITY = 3'b011,
        TX_STOP   = 3'b100
    } txState_type;

    typedef enum logic [2:0] {
        RX_IDLE   = 3'b000,
        RX_START  = 3'b001,
        RX_DATA   = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP   = 3'b100
    } rxState_type;

endpackage : uart_pkg

//--- dv/async_serial_uart_assertions.sv
// Port-level checker for the serial port
`timescale 1ns/10ps
module async_serial_uart_assertions #(
    parameter int unsigned FIFO_DEPTH = 16
)(
    input wire logic                     ref_clk,
    input wire logic                     rst_b,
    input wire uart_pkg::lineCfg_type    lineCfg,
    input wire logic                     fifoEn,
    input wire uart_pkg::intEnable_type  intEnable,
    input wire logic                     txWrite,
    input wire uart_pkg::lineStatus_type lineStatus,
    input wire uart_pkg::intId_type      intId,
    input wire logic                     irq,
    input wire logic                     txPin
);
    import uart_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Start bit held low for eight more clocks after it falls
    sequence startHeld;
        !txPin [*8];
    endsequence
    // Reset image, checked even while reset is low
    chk_reset_vals:
        assert property (disable iff (1'b0) !rst_b |=> txPin && !irq && lineStatus == 8'h60)
        else $error("reset values wrong");
    chk_irq_cause:
        assert property (irq == (intId != INT_NONE)) else $error("irq disagrees with cause");
    chk_start_after_wr:
        assert property (txWrite && lineStatus.txEmpty && !lineCfg.breakCtl |-> ##3 !txPin)
        else $error("no start bit after write");
    chk_holding_busy:
        assert property (txWrite && lineStatus.thrEmpty |-> ##2 !lineStatus.thrEmpty)
        else $error("holding empty after write");
    chk_start_width:
        assert property ($fell(txPin) && !lineCfg.breakCtl |=> startHeld)
        else $error("start bit too short");
    chk_idle_mark:
        assert property (lineStatus.txEmpty && !lineCfg.breakCtl |-> txPin)
        else $error("line not idle high");
    chk_line_first:
        assert property (intEnable.lineStat && $rose(lineStatus.frameErr || lineStatus.parityErr)
            |-> ##[0:2] intId == INT_LINE) else $error("line error not reported");
    chk_rx_irq:
        assert property (!fifoEn && intEnable.rxData && $rose(lineStatus.dataReady)
            |-> ##[0:2] (intId == INT_RXDATA || intId == INT_LINE)) else $error("rx cause missing");
    chk_quiet_off:
        assert property ((intEnable == 3'h0) [*3] |-> !irq) else $error("irq while disabled");
endmodule : async_serial_uart_assertions

bind async_serial_uart async_serial_uart_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .ref_clk, .rst_b, .lineCfg, .fifoEn, .intEnable, .txWrite, .lineStatus, .intId, .irq, .txPin);

//--- dv/serial_peer.sv
// Remote serial device on the line pins
`timescale 1ns/10ps
module serial_peer (
    input  wire logic txPin,
    output logic      rxPin
);
    real         bitNs = 666.667;
    int          capN  = 10;
    logic [11:0] cap;
    initial rxPin = 1'b1;
    // Sends a frame image, first bit first
    task automatic send(input logic [11:0] b, input int n);
        for (int i = 0; i < n; i++)
        begin
            rxPin = b[i];
            #(bitNs);
        end
        rxPin = 1'b1;
    endtask : send
    // Spurious low pulse of one clock
    task automatic blip();
        rxPin = 1'b0;
        #40;
        rxPin = 1'b1;
    endtask : blip
    // Samples outgoing frames at bit centres
    always @(negedge txPin)
    begin
        cap = '0;
        #(bitNs / 2);
        cap[0] = txPin;
        // Ends at mid stop bit so a back-to-back start is caught
        for (int i = 1; i < capN; i++)
        begin
            #(bitNs);
            cap[i] = txPin;
        end
    end
endmodule : serial_peer

//--- dv/tb_top.sv
// Self-checking bench for the serial port
`timescale 1ns/10ps
`define CHK(nm, e, a) begin nChecks++; if ((a) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", nm, e, a); end end
module tb_top;
    import uart_pkg::*;
    logic           ref_clk = 1'b0;
    logic           rst_b = 1'b0;
    logic           srcSel, fifoEn, rxFifoClear, txFifoClear, txWrite, rxRead;
    logic           intIdRead, lineStatusRead, irq, txPin, rxPin;
    logic [15:0]    divisor;
    logic [1:0]     rxTrigSel;
    logic [7:0]     txData, rxDataOut;
    lineCfg_type    lineCfg;
    intEnable_type  intEnable;
    lineStatus_type lineStatus;
    intId_type      intId;
    int             errors = 0;
    int             nChecks = 0;
    async_serial_uart u_dut (.ref_clk, .rst_b, .lineCfg, .divisor, .srcSel, .fifoEn,
        .rxFifoClear, .txFifoClear, .rxTrigSel, .intEnable, .txWrite, .txData, .rxRead,
        .intIdRead, .lineStatusRead, .rxPin, .rxDataOut, .lineStatus, .intId, .irq, .txPin);
    serial_peer u_peer (.txPin, .rxPin);
    initial forever #20 ref_clk = ~ref_clk;
    // Expected line image: start, data, parity, one stop
    function automatic logic [11:0] frame(input lineCfg_type c, input logic [7:0] d);
        int n;
        n = 5 + int'(c.wordLen);
        d = d & ~(8'hFF << n);
        frame = 12'(d) << 1;
        if (c.parityEn)
            frame[n + 1] = c.stickParity ? !c.evenParity : (c.evenParity ? ^d : ~^d);
        frame[n + 1 + int'(c.parityEn)] = 1'b1;
    endfunction : frame
    // Access helpers
    task automatic pulse(ref logic s);
        @(negedge ref_clk) s = 1'b1;
        @(negedge ref_clk) s = 1'b0;
    endtask : pulse
    task automatic wr(input logic [7:0] d);
        txData = d;
        pulse(txWrite);
    endtask : wr
    task automatic waitTx();
        repeat (3) @(negedge ref_clk);
        for (int i = 0; i < 9000 && lineStatus.txEmpty !== 1'b1; i++) @(negedge ref_clk);
        `CHK("tx idle", 1'b1, lineStatus.txEmpty)
    endtask : waitTx
    task automatic waitRdy();
        for (int i = 0; i < 9000 && lineStatus.dataReady !== 1'b1; i++) @(negedge ref_clk);
        `CHK("rx ready", 1'b1, lineStatus.dataReady)
        repeat (2) @(negedge ref_clk);
    endtask : waitRdy
    // Transmit formats, sources and holding depth
    task automatic t_tx();
        lineCfg_type cf [4] = '{7'h03, 7'h18, 7'h0A, 7'h3D};
        logic [7:0]  d;
        for (int i = 0; i < 5; i++)
        begin
            d = 8'hA5 + 8'(i * 37);
            lineCfg = cf[i % 4];
            srcSel = (i == 4);
            divisor = (i == 4) ? 16'h0002 : 16'h0001;
            u_peer.bitNs = srcSel ? 2000.0 : 666.667;
            u_peer.capN = 7 + int'(lineCfg.wordLen) + int'(lineCfg.parityEn);
            wr(d);
            waitTx();
            `CHK("tx frame", frame(lineCfg, d), u_peer.cap)
        end
        {srcSel, divisor} = {1'b0, 16'h0001};
        u_peer.bitNs = 666.667;
        u_peer.capN = 10;
        lineCfg = 7'h03;
        for (int f = 0; f < 2; f++)
        begin
            fifoEn = f[0];
            for (int i = 0; i < 3; i++) wr(8'hC0 + 8'(i));
            waitTx();
            `CHK("last tx", frame(lineCfg, 8'hC1 + 8'(f)), u_peer.cap)
        end
        fifoEn = 1'b0;
        $display("test tx done");
    endtask : t_tx
    // Receive, filtering, errors and priority
    task automatic t_rx();
        lineCfg = 7'h1B;
        intEnable = 3'h7;
        u_peer.blip();
        repeat (100) @(negedge ref_clk);
        `CHK("glitch", 1'b0, lineStatus.dataReady)
        u_peer.send(frame(lineCfg, 8'h96), 11);
        waitRdy();
        `CHK("rx data", 8'h96, rxDataOut)
        `CHK("rx cause", INT_RXDATA, intId)
        `CHK("irq", 1'b1, irq)
        u_peer.send(frame(lineCfg, 8'h3C), 11);
        repeat (2) @(negedge ref_clk);
        `CHK("overrun", 1'b1, lineStatus.overrun)
        `CHK("kept", 8'h96, rxDataOut)
        pulse(rxRead);
        u_peer.send(frame(lineCfg, 8'h96) ^ 12'h200, 11);
        waitRdy();
        `CHK("parity err", 1'b1, lineStatus.parityErr)
        `CHK("line cause", INT_LINE, intId)
        pulse(lineStatusRead);
        pulse(rxRead);
        u_peer.send(frame(lineCfg, 8'h5A) ^ 12'h400, 11);
        waitRdy();
        `CHK("frame err", 1'b1, lineStatus.frameErr)
        pulse(lineStatusRead);
        pulse(rxRead);
        repeat (3) @(negedge ref_clk);
        `CHK("tx empty cause", INT_THR, intId)
        pulse(intIdRead);
        repeat (3) @(negedge ref_clk);
        `CHK("no cause", INT_NONE, intId)
        `CHK("irq idle", 1'b0, irq)
        $display("test rx done");
    endtask : t_rx
    // Receive queue, trigger level and timeout
    task automatic t_fifo();
        {fifoEn, rxTrigSel, lineCfg} = {1'b1, 2'h1, 7'h03};
        for (int i = 0; i < 4; i++)
        begin
            u_peer.send(frame(lineCfg, 8'h30 + 8'(i)), 10);
            repeat (4) @(negedge ref_clk);
            `CHK("rx trigger", i == 3, intId == INT_RXDATA)
        end
        for (int i = 0; i < 4; i++)
        begin
            `CHK("fifo data", 8'h30 + 8'(i), rxDataOut)
            pulse(rxRead);
            repeat (2) @(negedge ref_clk);
        end
        u_peer.send(frame(lineCfg, 8'h34), 10);
        repeat (800) @(negedge ref_clk);
        `CHK("timeout cause", INT_TIMEOUT, intId)
        pulse(rxFifoClear);
        repeat (3) @(negedge ref_clk);
        `CHK("cleared", 1'b0, lineStatus.dataReady)
        $display("test fifo done");
    endtask : t_fifo
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial
    begin
        {srcSel, fifoEn, rxFifoClear, txFifoClear, txWrite, rxRead, intIdRead} = '0;
        {lineStatusRead, rxTrigSel, txData, lineCfg, intEnable} = '0;
        divisor = 16'h0001;
        repeat (10) @(negedge ref_clk);
        `CHK("reset status", 8'h60, lineStatus)
        rst_b = 1'b1;
        pulse(txFifoClear);
        t_tx();
        t_rx();
        t_fifo();
        wrap_up();
    end
    // Tests need about 0.2 ms; allow 1 ms
    initial
    begin
        #1000000;
        errors++;
        wrap_up();
    end
endmodule : tb_top
